/* File: core/bfp_pkg.sv */
// package: constants and types for the battery fault protection block
package bfp_pkg;
   localparam int CLK_MHZ = 125;
   // timing figures in their own units
   localparam int CHG_OC_DEG_NS = 1000;
   localparam int DSG_OC_DEG_US = 250;
   localparam int DSG_OC_RELAX_MS = 250;
   localparam int CHG_OC_LATCH_MS = 1000;
   localparam int SLEEP_DEG_US = 10;
   localparam int CHG_OC_DEG_CYC = (CHG_OC_DEG_NS * CLK_MHZ + 999) / 1000;
   localparam int DSG_OC_DEG_CYC = DSG_OC_DEG_US * CLK_MHZ;
   localparam int DSG_OC_RELAX_CYC = DSG_OC_RELAX_MS * 1000 * CLK_MHZ;
   localparam int CHG_OC_LATCH_CYC = CHG_OC_LATCH_MS * 1000 * CLK_MHZ;
   localparam int SLEEP_DEG_CYC = SLEEP_DEG_US * CLK_MHZ;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CHG_CUR = 8'h08;
   localparam logic [7:0] OFS_VLEVEL = 8'h0C;
   // control field positions
   localparam int CTL_OV_EN = 0;
   localparam int CTL_SINK_DIS = 1;
   localparam int CTL_COC_LO = 2;
   localparam int CTL_DOC_EN = 4;
   localparam int CTL_DOC_SEL = 5;
   localparam int CTL_LIN_EN = 6;
   localparam int CTL_SLEEP_EN = 7;
   localparam logic [7:0] CTRL_RST = 8'h81;
   // status positions
   localparam int ST_OV = 0;
   localparam int ST_COC = 1;
   localparam int ST_DOC = 2;
   localparam int ST_SLEEP = 3;
   // sense thresholds in mV
   localparam logic [7:0] COC_TH_01 = 8'h32;
   localparam logic [7:0] COC_TH_10 = 8'h4B;
   localparam logic [7:0] COC_TH_11 = 8'h64;
   localparam logic [9:0] DOC_CLAMP_LO = 10'h032;
   localparam logic [9:0] DOC_CLAMP_HI = 10'h0B4;
   // linear mode clamps in mA, gaps in mV
   localparam logic [11:0] TRICKLE_MA = 12'h080;
   localparam logic [11:0] CLAMP1_MA = 12'h200;
   localparam logic [11:0] CLAMP2_MA = 12'h080;
   localparam logic [15:0] GAP1_MV = 16'h03E8;
   localparam logic [15:0] GAP2_MV = 16'h0FA0;
   localparam logic [15:0] FLOOR_MV = 16'h1388;
   localparam logic [15:0] HEAD_MV = 16'h00A0;
   typedef enum logic [2:0] {
      DOC_IDLE = 3'b001,
      DOC_TRIP = 3'b010,
      DOC_RELAX = 3'b100
   } bfp_doc_state_t;
   typedef struct packed {
      logic converter_stop;
      logic power_good_pull_low;
      logic sink_enable;
      logic switch_charge_off;
   } bfp_drive_t;
endpackage

/* File: core/bfp_top.sv */
// battery fault protection: comparators, deglitch, status and ahb-lite registers
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] overvoltage acts only when present, charging forward
// [R2] overvoltage sets above 108%, clears below 106%
// [R3] overvoltage protection enabled after reset, zero disables
// [R4] overvoltage while charging stops converter, pulls power-good
// [R5] overvoltage while not charging leaves converter, power-good
// [R6] overvoltage status sticky until host read
// [R7] overvoltage drives 20 mA sink unless disabled
// [R8] charge overcurrent field: off, 50/75/100 mV
// [R9] after 1 us: zero current, switch off, status; code keeps the switch on while linear mode is active
// [R10] charge overcurrent status read-clears only after 1 s
// [R11] nonzero current writes rejected during 1 s
// [R12] charge overcurrent leaves power-good and supplement alone
// [R13] discharge overcurrent only reverse mode, when enabled
// [R14] discharge threshold 200% or 300% of level two
// [R15] discharge threshold clamped 50 to 180 mV
// [R16] after 250 us: status, stop converter, switch unchanged
// [R17] resume 250 ms after clear; status read-clears
// [R18] linear mode regulates minimum system, gate controls current
// [R19] linear current is lowest of four clamps
// [R20] linear off: switch full; system target 5V or bat+160mV; code targets the battery voltage while charging is enabled
// [R21] sleep comparator enabled after reset, zero disables
// [R22] sleep fault stops converter, read-clear status, no power-good
// [R23] interval counters restart when qualified input changes
module bfp_top import bfp_pkg::*; #(
   parameter int DSG_RELAX = DSG_OC_RELAX_CYC,
   parameter int CHG_LATCH = CHG_OC_LATCH_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HSEL,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic BATTERY_PRESENT,
   input wire logic CHARGE_ENABLE,
   input wire logic REVERSE_MODE,
   input wire logic [15:0] BATTERY_MV,
   input wire logic [15:0] CHARGE_TARGET_MV,
   input wire logic [15:0] MIN_SYSTEM_MV,
   input wire logic [7:0] CHARGE_SENSE_MV,
   input wire logic [7:0] DISCHARGE_SENSE_MV,
   input wire logic [7:0] DISCHARGE_LEVEL_TWO_MV,
   input wire logic [11:0] PRECHARGE_LIMIT_MA,
   input wire logic SLEEP_COMPARATOR_TRIP,
   output logic CONVERTER_STOP,
   output logic POWER_GOOD_OUTPUT,
   output logic POWER_GOOD_OE_N,
   output logic SINK_ENABLE,
   output logic SWITCH_CHARGE_OFF,
   output logic LINEAR_ACTIVE,
   output logic [11:0] LINEAR_LIMIT_MA,
   output logic [15:0] SYSTEM_TARGET_MV
);
   // ---------------- bus slave ----------------
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [3:0] status_ff, nxt_status;
   logic [15:0] chg_cur_ff, nxt_chg_cur;
   logic aw_ff, ar_ff;
   logic [7:0] addr_ff;
   logic [31:0] rdata_ff;
   wire take = HSEL & HREADY & HTRANS[1];
   wire wr_ctrl = aw_ff & (addr_ff == OFS_CTRL);
   wire wr_cur = aw_ff & (addr_ff == OFS_CHG_CUR);
   wire rd_stat = take & ~HWRITE & (HADDR[7:0] == OFS_STATUS);
   // ---------------- overvoltage ----------------
   logic ov_cmp_ff;
   wire [23:0] bat_x100 = 24'(BATTERY_MV) * 24'd100;
   wire [23:0] tgt_x108 = 24'(CHARGE_TARGET_MV) * 24'd108;
   wire [23:0] tgt_x106 = 24'(CHARGE_TARGET_MV) * 24'd106;
   wire ov_qual = ctrl_ff[CTL_OV_EN] & BATTERY_PRESENT & CHARGE_ENABLE
                  & ~REVERSE_MODE; // [R1] [R3]
   wire ov_nxt = ov_cmp_ff ? (bat_x100 >= tgt_x106) : (bat_x100 > tgt_x108); // [R2]
   wire ov_act = ov_cmp_ff & ov_qual; // [R4] [R5]
   // ---------------- charge overcurrent ----------------
   logic [1:0] coc_cfg;
   logic [7:0] coc_th;
   assign coc_cfg = ctrl_ff[CTL_COC_LO +: 2];
   assign coc_th = (coc_cfg == 2'b01) ? COC_TH_01 :
                   (coc_cfg == 2'b10) ? COC_TH_10 : COC_TH_11; // [R8]
   wire coc_raw = (coc_cfg != 2'b00) & (CHARGE_SENSE_MV > coc_th);
   logic [7:0] coc_cnt_ff;
   logic coc_armed_ff;
   logic [31:0] latch_cnt_ff;
   wire coc_fire = coc_raw & coc_armed_ff & (coc_cnt_ff == 8'(CHG_OC_DEG_CYC - 1));
   wire latching = latch_cnt_ff != 32'h0;
   // ---------------- discharge overcurrent ----------------
   wire [9:0] doc_mult = ctrl_ff[CTL_DOC_SEL] ? 10'(DISCHARGE_LEVEL_TWO_MV) * 10'd3
                                               : 10'(DISCHARGE_LEVEL_TWO_MV) * 10'd2; // [R14]
   wire [9:0] doc_th = (doc_mult < DOC_CLAMP_LO) ? DOC_CLAMP_LO :
                       (doc_mult > DOC_CLAMP_HI) ? DOC_CLAMP_HI : doc_mult; // [R15]
   wire doc_raw = ctrl_ff[CTL_DOC_EN] & REVERSE_MODE
                  & (10'(DISCHARGE_SENSE_MV) > doc_th); // [R13]
   bfp_doc_state_t doc_st_ff, nxt_doc_st;
   logic [31:0] doc_cnt_ff, nxt_doc_cnt;
   // ---------------- sleep comparator ----------------
   logic sleep_ff;
   logic [15:0] sleep_cnt_ff;
   wire sleep_in = ctrl_ff[CTL_SLEEP_EN] & SLEEP_COMPARATOR_TRIP; // [R21]
   wire sleep_flip = (sleep_in != sleep_ff) & (sleep_cnt_ff == 16'(SLEEP_DEG_CYC - 1));
   // ---------------- linear mode ----------------
   wire [15:0] gap = (MIN_SYSTEM_MV > BATTERY_MV) ? MIN_SYSTEM_MV - BATTERY_MV : 16'h0;
   wire lin_on = ctrl_ff[CTL_LIN_EN] & CHARGE_ENABLE & (BATTERY_MV < MIN_SYSTEM_MV); // [R18]
   wire [11:0] lim_a = (PRECHARGE_LIMIT_MA < TRICKLE_MA) ? PRECHARGE_LIMIT_MA : TRICKLE_MA;
   wire [11:0] lim_gap = (gap > GAP2_MV) ? CLAMP2_MA :
                         (gap > GAP1_MV) ? CLAMP1_MA : 12'hFFF;
   wire [11:0] lin_lim = (lim_a < lim_gap) ? lim_a : lim_gap; // [R19]
   wire [15:0] sys_tgt = lin_on ? MIN_SYSTEM_MV :
                         CHARGE_ENABLE ? BATTERY_MV :
                         (BATTERY_MV < FLOOR_MV) ? FLOOR_MV : 16'(BATTERY_MV + HEAD_MV); // [R20]
   // ---------------- next-state ----------------
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = HWDATA[7:0];
      end
   end
   always_comb begin
      nxt_chg_cur = chg_cur_ff;
      if (wr_cur && (!latching || HWDATA[15:0] == 16'h0)) begin
         nxt_chg_cur = HWDATA[15:0]; // [R11]
      end
      if (coc_fire) begin
         nxt_chg_cur = 16'h0; // [R9]
      end
   end
   // read clears first, then events set, so a same-cycle event wins
   always_comb begin
      nxt_status = status_ff;
      if (rd_stat) begin
         nxt_status[ST_OV] = 1'b0; // [R6]
         nxt_status[ST_DOC] = 1'b0; // [R17]
         nxt_status[ST_SLEEP] = 1'b0; // [R22]
         if (!latching) begin
            nxt_status[ST_COC] = 1'b0; // [R10]
         end
      end
      if (ov_act) nxt_status[ST_OV] = 1'b1;
      if (coc_fire) nxt_status[ST_COC] = 1'b1;
      if (doc_st_ff == DOC_IDLE && nxt_doc_st == DOC_TRIP) nxt_status[ST_DOC] = 1'b1;
      if (sleep_ff || (sleep_flip && sleep_in)) nxt_status[ST_SLEEP] = 1'b1;
   end
   always_comb begin
      nxt_doc_st = doc_st_ff;
      nxt_doc_cnt = doc_cnt_ff + 32'h1;
      unique case (doc_st_ff)
         DOC_IDLE: begin
            if (!doc_raw) begin
               nxt_doc_cnt = 32'h0; // [R23]
            end else if (doc_cnt_ff == 32'(DSG_OC_DEG_CYC - 1)) begin
               nxt_doc_st = DOC_TRIP; // [R16]
               nxt_doc_cnt = 32'h0;
            end
         end
         DOC_TRIP: begin
            nxt_doc_cnt = 32'h0;
            if (!doc_raw) begin
               nxt_doc_st = DOC_RELAX;
            end
         end
         DOC_RELAX: begin
            if (doc_raw) begin
               nxt_doc_st = DOC_TRIP; // [R23]
               nxt_doc_cnt = 32'h0;
            end else if (doc_cnt_ff == 32'(DSG_RELAX - 1)) begin
               nxt_doc_st = DOC_IDLE; // [R17]
               nxt_doc_cnt = 32'h0;
            end
         end
         default: begin
            nxt_doc_st = DOC_IDLE;
            nxt_doc_cnt = 32'h0;
         end
      endcase
   end
   bfp_drive_t drv;
   assign drv.converter_stop = ov_act | (doc_st_ff != DOC_IDLE) | sleep_ff; // [R4] [R16] [R22]
   assign drv.power_good_pull_low = ov_act; // [R4] [R12] [R22]
   assign drv.sink_enable = ov_act & ~ctrl_ff[CTL_SINK_DIS]; // [R7]
   assign drv.switch_charge_off = (chg_cur_ff == 16'h0) & ~lin_on; // [R9] [R12]
   wire [31:0] rd_mux = (HADDR[7:0] == OFS_CTRL) ? {24'h0, ctrl_ff} :
                        (HADDR[7:0] == OFS_STATUS) ? {28'h0, status_ff} :
                        (HADDR[7:0] == OFS_CHG_CUR) ? {16'h0, chg_cur_ff} :
                        (HADDR[7:0] == OFS_VLEVEL) ? {16'h0, sys_tgt} : 32'h0;
   // ---------------- registers ----------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         ctrl_ff <= CTRL_RST; // [R3] [R21]
         status_ff <= 4'h0;
         chg_cur_ff <= 16'h0;
         aw_ff <= 1'b0;
         ar_ff <= 1'b0;
         addr_ff <= 8'h00;
         rdata_ff <= 32'h0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         status_ff <= nxt_status;
         chg_cur_ff <= nxt_chg_cur;
         aw_ff <= take & HWRITE;
         ar_ff <= take & ~HWRITE;
         addr_ff <= HADDR[7:0];
         rdata_ff <= (take && !HWRITE) ? rd_mux : 32'h0;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         ov_cmp_ff <= 1'b0;
         coc_cnt_ff <= 8'h0;
         coc_armed_ff <= 1'b1;
         latch_cnt_ff <= 32'h0;
         doc_st_ff <= DOC_IDLE;
         doc_cnt_ff <= 32'h0;
         sleep_ff <= 1'b0;
         sleep_cnt_ff <= 16'h0;
      end else begin
         ov_cmp_ff <= ov_nxt;
         coc_cnt_ff <= coc_raw ? 8'(coc_cnt_ff + 8'h1) : 8'h0; // [R23]
         coc_armed_ff <= coc_fire ? 1'b0 : (coc_armed_ff | ~coc_raw); // [R9]
         latch_cnt_ff <= coc_fire ? 32'(CHG_LATCH) :
                         latching ? latch_cnt_ff - 32'h1 : 32'h0; // [R10]
         doc_st_ff <= nxt_doc_st;
         doc_cnt_ff <= nxt_doc_cnt;
         sleep_ff <= sleep_flip ? sleep_in : sleep_ff; // [R22]
         sleep_cnt_ff <= (sleep_in == sleep_ff) ? 16'h0 : 16'(sleep_cnt_ff + 16'h1); // [R23]
      end
   end
   // ---------------- outputs ----------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         CONVERTER_STOP <= 1'b0;
         POWER_GOOD_OUTPUT <= 1'b0;
         POWER_GOOD_OE_N <= 1'b1;
         SINK_ENABLE <= 1'b0;
         SWITCH_CHARGE_OFF <= 1'b1;
         LINEAR_ACTIVE <= 1'b0;
         LINEAR_LIMIT_MA <= 12'h0;
         SYSTEM_TARGET_MV <= 16'h0;
         HRDATA <= 32'h0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         CONVERTER_STOP <= drv.converter_stop;
         POWER_GOOD_OUTPUT <= 1'b0;
         POWER_GOOD_OE_N <= ~drv.power_good_pull_low; // open drain: low when pulling
         SINK_ENABLE <= drv.sink_enable;
         SWITCH_CHARGE_OFF <= drv.switch_charge_off;
         LINEAR_ACTIVE <= lin_on;
         LINEAR_LIMIT_MA <= lin_on ? lin_lim : 12'h0;
         SYSTEM_TARGET_MV <= sys_tgt;
         HRDATA <= (take && !HWRITE) ? rd_mux : rdata_ff & {32{ar_ff & 1'b0}};
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: verification/bfp_assertions.sv */
// concurrent checks on the fault protection ports
`timescale 1ns/1ps
`default_nettype none
module bfp_assertions import bfp_pkg::*; (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic BATTERY_PRESENT,
   input wire logic CHARGE_ENABLE,
   input wire logic REVERSE_MODE,
   input wire logic [15:0] BATTERY_MV,
   input wire logic [15:0] CHARGE_TARGET_MV,
   input wire logic [11:0] PRECHARGE_LIMIT_MA,
   input wire logic SLEEP_COMPARATOR_TRIP,
   input wire logic CONVERTER_STOP,
   input wire logic POWER_GOOD_OE_N,
   input wire logic SINK_ENABLE,
   input wire logic LINEAR_ACTIVE,
   input wire logic [11:0] LINEAR_LIMIT_MA,
   input wire logic [15:0] SYSTEM_TARGET_MV
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   wire logic ov_hi = 32'(BATTERY_MV) * 100 > 32'(CHARGE_TARGET_MV) * 108;
   wire logic ov_lo = 32'(BATTERY_MV) * 100 < 32'(CHARGE_TARGET_MV) * 106;
   wire logic no_q = !CHARGE_ENABLE || REVERSE_MODE || !BATTERY_PRESENT;
   sequence s_unqual; no_q [*3]; endsequence
   a_ov_ignored: assert property (s_unqual |-> POWER_GOOD_OE_N)
      else $error("power good pulled while overvoltage unqualified");
   a_ov_trip_cause: assert property ($fell(POWER_GOOD_OE_N) |-> $past(!ov_lo, 2) && $past(!no_q))
      else $error("power good pulled without overvoltage");
   a_ov_release: assert property ($rose(POWER_GOOD_OE_N) |-> $past(!ov_hi, 2) || $past(no_q))
      else $error("power good released while overvoltage high");
   a_pg_with_stop: assert property (!POWER_GOOD_OE_N |-> CONVERTER_STOP)
      else $error("power good pulled with converter running");
   a_sink_with_ov: assert property (SINK_ENABLE |-> !POWER_GOOD_OE_N)
      else $error("sink on without overvoltage");
   a_sleep_deglitch: assert property ($rose(SLEEP_COMPARATOR_TRIP) && !CONVERTER_STOP
      |=> !CONVERTER_STOP [*8]) else $error("sleep fault acted before deglitch");
   a_linear_bound: assert property (LINEAR_ACTIVE && $stable(PRECHARGE_LIMIT_MA) |->
      LINEAR_LIMIT_MA <= TRICKLE_MA && LINEAR_LIMIT_MA <= PRECHARGE_LIMIT_MA)
      else $error("linear limit above a clamp");
   a_idle_target: assert property (!CHARGE_ENABLE && $stable(CHARGE_ENABLE)
      && $stable(BATTERY_MV) && $past(RESETN, 2) |-> SYSTEM_TARGET_MV ==
      (BATTERY_MV < FLOOR_MV ? FLOOR_MV : BATTERY_MV + HEAD_MV))
      else $error("system target wrong with charging off");
endmodule
bind bfp_top bfp_assertions bfp_assertions_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
   .BATTERY_PRESENT(BATTERY_PRESENT), .CHARGE_ENABLE(CHARGE_ENABLE),
   .REVERSE_MODE(REVERSE_MODE), .BATTERY_MV(BATTERY_MV), .CHARGE_TARGET_MV(CHARGE_TARGET_MV),
   .PRECHARGE_LIMIT_MA(PRECHARGE_LIMIT_MA), .SLEEP_COMPARATOR_TRIP(SLEEP_COMPARATOR_TRIP),
   .CONVERTER_STOP(CONVERTER_STOP), .POWER_GOOD_OE_N(POWER_GOOD_OE_N),
   .SINK_ENABLE(SINK_ENABLE), .LINEAR_ACTIVE(LINEAR_ACTIVE),
   .LINEAR_LIMIT_MA(LINEAR_LIMIT_MA), .SYSTEM_TARGET_MV(SYSTEM_TARGET_MV));
`default_nettype wire

/* File: verification/bfp_host_model.sv */
// ahb-lite master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module bfp_host_model (
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata
);
   logic hung = 1'b0;
   initial begin
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end
   // bounded wait so a stuck slave cannot hang the run
   task automatic wait_ready();
      @(posedge clk);
      for (int i = 0; i < 16 && hready !== 1'b1; i++) @(posedge clk);
      if (hready !== 1'b1) hung = 1'b1;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
endmodule
`default_nettype wire

/* File: verification/test_battery_fault_protection.sv */
// self-checking bench for the battery fault protection block
`timescale 1ns/1ps
`default_nettype none
module test_battery_fault_protection;
   import bfp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, chg_en = 1'b0, rev = 1'b0, sleep = 1'b0;
   logic [15:0] bat = 16'h0FA0, tgt = 16'h2710, vmin = 16'h1F40, sys;
   logic [7:0] cs = 8'h00, ds = 8'h00, lv2 = 8'h1E;
   logic [11:0] pre = 12'h064, lim;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans;
   logic hwrite, hready, hresp, stop, pgo, pg_oe_n, sink, swoff, lin;
   int failures = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   bfp_host_model bfp_host_model_inst (.clk(clk), .hready(hready), .hrdata(hrdata),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
   bfp_top #(.DSG_RELAX(200), .CHG_LATCH(500)) bfp_top_inst (.CLK_SYS(clk), .RESETN(rst_n),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HSEL(1'b1),
      .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .BATTERY_PRESENT(1'b1), .CHARGE_ENABLE(chg_en), .REVERSE_MODE(rev), .BATTERY_MV(bat),
      .CHARGE_TARGET_MV(tgt), .MIN_SYSTEM_MV(vmin), .CHARGE_SENSE_MV(cs),
      .DISCHARGE_SENSE_MV(ds), .DISCHARGE_LEVEL_TWO_MV(lv2), .PRECHARGE_LIMIT_MA(pre),
      .SLEEP_COMPARATOR_TRIP(sleep), .CONVERTER_STOP(stop), .POWER_GOOD_OUTPUT(pgo),
      .POWER_GOOD_OE_N(pg_oe_n), .SINK_ENABLE(sink), .SWITCH_CHARGE_OFF(swoff),
      .LINEAR_ACTIVE(lin), .LINEAR_LIMIT_MA(lim), .SYSTEM_TARGET_MV(sys));
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] v);
      bfp_host_model_inst.xfer(w, a, v, d);
      if (bfp_host_model_inst.hung) begin
         failures++;
         final_report();
      end
   endtask
   task automatic t_reset();
      xf(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", d, {24'h0, CTRL_RST});
      xf(1'b0, 8'h10, 32'h0);
      chk("unmapped", d, 32'h0);
      chk("okay", hresp, 32'h0);
      chk("pg level", pgo, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_ov();
      chg_en <= 1'b1;
      bat <= 16'h2AF8;
      cyc(4);
      chk("ov", {pg_oe_n, stop, sink}, 3'b011);
      bat <= 16'h29CC;
      cyc(4);
      chk("ov band", pg_oe_n, 1'b0);
      bat <= 16'h2904;
      cyc(4);
      chk("ov off", {pg_oe_n, stop, sink}, 3'b100);
      xf(1'b0, OFS_STATUS, 32'h0);
      chk("ov st", d, 32'h1);
      xf(1'b0, OFS_STATUS, 32'h0);
      chk("ov clr", d, 32'h0);
      xf(1'b1, OFS_CTRL, 32'h83);
      bat <= 16'h2AF8;
      cyc(4);
      chk("sink dis", {pg_oe_n, sink}, 2'b00);
      bat <= 16'h2904;
      xf(1'b1, OFS_CTRL, 32'h80);
      bat <= 16'h2AF8;
      cyc(4);
      chk("ov dis", {pg_oe_n, stop}, 2'b10);
      chg_en <= 1'b0;
      xf(1'b1, OFS_CTRL, 32'h81);
      cyc(4);
      chk("no chg", {pg_oe_n, stop, sink}, 3'b100);
      bat <= 16'h2904;
      xf(1'b0, OFS_STATUS, 32'h0);
      $display("ov test done");
   endtask
   task automatic t_coc();
      xf(1'b1, OFS_CTRL, 32'h85);
      xf(1'b1, OFS_CHG_CUR, 32'h100);
      cs <= 8'h3C;
      cyc(120);
      chk("coc wait", swoff, 1'b0);
      cyc(20);
      chk("coc", {swoff, pg_oe_n}, 2'b11);
      cs <= 8'h00;
      xf(1'b1, OFS_CHG_CUR, 32'h100);
      xf(1'b0, OFS_CHG_CUR, 32'h0);
      chk("cur lock", d, 32'h0);
      xf(1'b0, OFS_STATUS, 32'h0);
      xf(1'b0, OFS_STATUS, 32'h0);
      chk("coc held", d[1], 1'b1);
      cyc(500);
      xf(1'b0, OFS_STATUS, 32'h0);
      xf(1'b0, OFS_STATUS, 32'h0);
      chk("coc clr", d[1], 1'b0);
      xf(1'b1, OFS_CHG_CUR, 32'h100);
      xf(1'b0, OFS_CHG_CUR, 32'h0);
      chk("cur again", d, 32'h100);
      $display("charge overcurrent test done");
   endtask
   task automatic t_doc();
      xf(1'b1, OFS_CTRL, 32'hB1);
      rev <= 1'b1;
      ds <= 8'h46;
      cyc(31400);
      chk("doc 300", stop, 1'b0);
      xf(1'b1, OFS_CTRL, 32'h91);
      cyc(31200);
      chk("doc wait", stop, 1'b0);
      cyc(100);
      chk("doc", {stop, swoff}, 2'b10);
      ds <= 8'h00;
      cyc(150);
      chk("doc relax", stop, 1'b1);
      cyc(100);
      chk("doc resume", stop, 1'b0);
      xf(1'b0, OFS_STATUS, 32'h0);
      chk("doc st", d, 32'h4);
      rev <= 1'b0;
      $display("discharge overcurrent test done");
   endtask
   task automatic t_sleep();
      sleep <= 1'b1;
      cyc(1200);
      chk("slp wait", stop, 1'b0);
      cyc(100);
      chk("slp", {stop, pg_oe_n}, 2'b11);
      sleep <= 1'b0;
      cyc(1200);
      chk("slp hold", stop, 1'b1);
      cyc(100);
      chk("slp off", stop, 1'b0);
      xf(1'b0, OFS_STATUS, 32'h0);
      chk("slp st", d, 32'h8);
      $display("sleep test done");
   endtask
   task automatic t_lin();
      xf(1'b1, OFS_CTRL, 32'hC1);
      chg_en <= 1'b1;
      bat <= 16'h1388;
      cyc(4);
      chk("lin", {lin, lim, sys}, {1'b1, 12'h064, 16'h1F40});
      pre <= 12'h12C;
      cyc(4);
      chk("lin clamp", {lim, pre}, {TRICKLE_MA, 12'h12C});
      chg_en <= 1'b0;
      bat <= 16'h0FA0;
      cyc(4);
      chk("floor", {lin, sys}, {1'b0, FLOOR_MV});
      bat <= 16'h1B58;
      cyc(4);
      chk("head", sys, 32'h1BF8);
      $display("linear test done");
   endtask
   initial begin
      cyc(4);
      rst_n <= 1'b1;
      cyc(1);
      t_reset();
      t_ov();
      t_coc();
      t_doc();
      t_sleep();
      t_lin();
      final_report();
   end
   initial begin
      cyc(90000);
      failures++;
      final_report();
   end
endmodule
`default_nettype wire
